// file: rtl/pbs_sram_top.sv
// Notes on behaviour
// - every synchronous pin is registered on the rising clock edge
// - address and chip selects latch only when an address strobe is low
// - later burst addresses come from the counter, stepped by advance
// - two-bit counter covers four word positions from the start address
// - interleaved and linear burst orders are both offered
// - address, data and write controls registered together, write self-timed
// - byte selects choose which of the four bytes a write updates
// - global write low writes all bytes regardless of byte controls, except on a processor strobe
// - output enable and sleep gate the output drivers without clock sampling
// - read data passes an output register stage
// - first read word three clocks after start, then one per clock
// - inactive chip selects at a strobe deselect within one clock
// - array is 256K words of 36 bits (the 512K of 18 variant is not built)
// - latched low two address bits load counter, upper bits fixed
module pbs_sram_top
   import pbs_pkg::*;
(
   input  wire logic              sys_clk_i,
   input  wire logic              reset_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic              proc_addr_strobe_n_i,
   input  wire logic              ctrl_addr_strobe_n_i,
   input  wire logic              burst_advance_n_i,
   input  wire logic              chip_sel_primary_n_i,
   input  wire logic              chip_sel_depth_hi_i,
   input  wire logic              chip_sel_depth_lo_n_i,
   input  wire logic [BYTES-1:0]  byte_write_sel_n_i,
   input  wire logic              byte_write_en_n_i,
   input  wire logic              all_bytes_write_n_i,
   input  wire logic              burst_order_linear_i,
   input  wire logic              output_enable_n_i,
   input  wire logic              sleep_request_i,
   input  wire logic [DQ_W-1:0]   data_i,
   output logic      [DQ_W-1:0]   data_o,
   output logic                   data_oe_o,
   input  wire logic [BYTES-1:0]  parity_io_i,
   output logic      [BYTES-1:0]  parity_io_o,
   output logic                   parity_io_oe_o
);

   typedef struct packed {
      pbs_pins_t                pins;
      logic                     active;
      logic [ADDR_W-1:LOW_W]    addr_hi;
      pbs_beat_t                beat;
      logic                     out_valid;
      logic [WORD_W-1:0]        out_data;
      logic                     sleep_meta;
      logic                     sleep_s;
   } pbs_top_state_t;

   localparam pbs_top_state_t TOP_RESET = '{pins: PINS_RESET, default: '0};

   pbs_top_state_t    st_r;
   pbs_top_state_t    st_nxt;
   logic [WORD_W-1:0] mem [WORDS];
   logic [WORD_W-1:0] wd;
   logic [WORD_W-1:0] rd_data;
   logic [BYTES-1:0]  wr_mask;
   logic [LOW_W-1:0]  ctr_low;
   logic              strobe;
   logic              enabled;
   logic              rd_only;
   logic              stall;
   logic              push;
   logic              beat_write;
   logic              ctr_load;
   logic              ctr_step;
   logic              fifo_in_ready;
   logic              fifo_out_valid;
   logic [WORD_W-1:0] fifo_out_data;

   // ==========================================================
   // pin packing
   // ==========================================================
   always_comb begin
      wd = '0;
      for (int k = 0; k < BYTES; k++) begin
         wd[k*BYTE_W +: BYTE_W] = {parity_io_i[k], data_i[k*DQ_BYTE_W +: DQ_BYTE_W]};
      end
   end

   always_comb begin
      data_o      = '0;
      parity_io_o = '0;
      for (int k = 0; k < BYTES; k++) begin
         data_o[k*DQ_BYTE_W +: DQ_BYTE_W] = st_r.out_data[k*BYTE_W +: DQ_BYTE_W];
         parity_io_o[k] = st_r.out_data[k*BYTE_W + DQ_BYTE_W];
      end
   end

   // output enable and sleep reach the drivers with no clock in the path
   assign data_oe_o      = st_r.out_valid && !output_enable_n_i && !sleep_request_i;
   assign parity_io_oe_o = data_oe_o;

   // ==========================================================
   // access decode from the registered pins
   // ==========================================================
   assign strobe  = !st_r.pins.strobe_p_n || !st_r.pins.strobe_c_n;
   assign enabled = !st_r.pins.cs1_n && st_r.pins.cs2 && !st_r.pins.cs3_n;
   assign rd_only = !st_r.pins.strobe_p_n;

   // byte controls need byte enable and selects low on the same edge
   assign wr_mask = !st_r.pins.gw_n  ? MASK_ALL :
                    !st_r.pins.bwe_n ? ~st_r.pins.bw_n :
                    MASK_NONE;

   // sleep freezes the pipe; a full buffer holds the pending read beat
   assign push       = st_r.beat.valid && st_r.beat.rd && !st_r.sleep_s;
   assign beat_write = st_r.beat.valid && !st_r.beat.rd && !st_r.sleep_s;
   assign stall      = st_r.sleep_s || (push && !fifo_in_ready);

   assign ctr_load = !stall && strobe && enabled;
   assign ctr_step = !stall && !strobe && st_r.active && !st_r.pins.adv_n;

   pbs_burst_ctr u_ctr (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .load_i    (ctr_load),
      .start_i   (st_r.pins.addr[LOW_W-1:0]),
      .step_i    (ctr_step),
      .linear_i  (st_r.pins.order_lin),
      .low_o     (ctr_low)
   );

   // ==========================================================
   // state update
   // ==========================================================
   always_comb begin
      st_nxt = st_r;

      st_nxt.pins.strobe_p_n = proc_addr_strobe_n_i;
      st_nxt.pins.strobe_c_n = ctrl_addr_strobe_n_i;
      st_nxt.pins.adv_n      = burst_advance_n_i;
      st_nxt.pins.cs1_n      = chip_sel_primary_n_i;
      st_nxt.pins.cs2        = chip_sel_depth_hi_i;
      st_nxt.pins.cs3_n      = chip_sel_depth_lo_n_i;
      st_nxt.pins.gw_n       = all_bytes_write_n_i;
      st_nxt.pins.bwe_n      = byte_write_en_n_i;
      st_nxt.pins.bw_n       = byte_write_sel_n_i;
      st_nxt.pins.order_lin  = burst_order_linear_i;
      st_nxt.pins.addr       = addr_i;
      st_nxt.pins.wdata      = wd;

      // internal copy of sleep, only for freezing the pipe
      st_nxt.sleep_meta = sleep_request_i;
      st_nxt.sleep_s    = st_r.sleep_meta;

      if (!stall) begin
         st_nxt.beat.valid = 1'b0;
         if (strobe) begin
            st_nxt.active = enabled;
            if (enabled) begin
               st_nxt.addr_hi = st_r.pins.addr[ADDR_W-1:LOW_W];
            end
         end
         if (st_nxt.active) begin
            st_nxt.beat.valid = 1'b1;
            st_nxt.beat.addr  = {st_nxt.addr_hi, ctr_low};
            st_nxt.beat.rd    = (strobe && rd_only) || (wr_mask == MASK_NONE);
            st_nxt.beat.mask  = st_nxt.beat.rd ? MASK_NONE : wr_mask;
            st_nxt.beat.data  = st_r.pins.wdata;
         end
      end

      st_nxt.out_valid = fifo_out_valid && !st_r.sleep_s;
      if (st_nxt.out_valid) begin
         st_nxt.out_data = fifo_out_data;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         st_r <= TOP_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // storage array
   // ==========================================================
   // contents have no reset, as in a real array
   always_ff @(posedge sys_clk_i) begin
      if (beat_write) begin
         for (int k = 0; k < BYTES; k++) begin
            if (st_r.beat.mask[k]) begin
               mem[st_r.beat.addr][k*BYTE_W +: BYTE_W] <= st_r.beat.data[k*BYTE_W +: BYTE_W];
            end
         end
      end
   end

   assign rd_data = mem[st_r.beat.addr];

   // ==========================================================
   // read buffer
   // ==========================================================
   // drained every clock outside sleep and untouched while asleep, so it never holds more than one word
   pbs_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_rd_fifo (
      .sys_clk_i   (sys_clk_i),
      .reset_i     (reset_i),
      .in_valid_i  (push),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (rd_data),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (!st_r.sleep_s),
      .out_data_o  (fifo_out_data)
   );

   // ==========================================================
   // checks
   // ==========================================================
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);

   AST_INPUT_REG: assert property (
      (strobe && enabled && !stall)
      |=> st_r.beat.data == $past(wd, 2)
          && st_r.addr_hi == $past(addr_i[ADDR_W-1:LOW_W], 2))
      else $error("start beat not built from pins sampled two edges back");

   AST_STROBE_ONLY: assert property (
      (!strobe || stall) |=> $stable(st_r.addr_hi))
      else $error("address latched without a strobe");

   AST_ADV_HOLD: assert property (
      (!stall && !strobe && st_r.active && st_r.pins.adv_n)
      |=> st_r.beat.addr == $past(st_r.beat.addr))
      else $error("burst address moved without advance");

   AST_SELF_TIMED: assert property (
      (beat_write && st_r.beat.mask == MASK_ALL)
      |=> mem[$past(st_r.beat.addr)] == $past(st_r.beat.data))
      else $error("full write did not complete in one clock");

   AST_BYTE_SEL: assert property (
      (!stall && st_nxt.active && !(strobe && rd_only)
       && st_r.pins.gw_n && !st_r.pins.bwe_n && st_r.pins.bw_n != MASK_ALL)
      |=> st_r.beat.mask == ~$past(st_r.pins.bw_n))
      else $error("byte selects not honoured");

   AST_GLOBAL_WRITE: assert property (
      (!stall && st_nxt.active && !(strobe && rd_only) && !st_r.pins.gw_n)
      |=> st_r.beat.mask == MASK_ALL && !st_r.beat.rd)
      else $error("global write did not select all bytes");

   AST_SLEEP_OFF: assert property (
      sleep_request_i |-> !data_oe_o)
      else $error("data driven while asleep");

   AST_OUT_STAGE: assert property (
      st_r.out_valid |-> $past(fifo_out_valid) && st_r.out_data == $past(fifo_out_data))
      else $error("output register not loaded from the read pipe");

   AST_LATENCY: assert property (
      (push && !fifo_out_valid)
      |-> ##2 (st_r.out_valid || $past(st_r.sleep_s)))
      else $error("read word not on the pins two clocks after issue");

   AST_DESELECT: assert property (
      (!stall && strobe && !enabled) |=> !st_r.active && !st_r.beat.valid)
      else $error("deselect took more than one clock");

   AST_OE_GATE: assert property (
      (output_enable_n_i || !st_r.out_valid) |-> !data_oe_o && !parity_io_oe_o)
      else $error("data driven outside a read phase");

   // ==========================================================
   // freeze, hold and read-start checks
   // ==========================================================
   // sleep must freeze the access stage, not only mask the drivers
   AST_SLEEP_FREEZE: assert property (
      st_r.sleep_s |=> $stable(st_r.beat) && $stable(st_r.active))
      else $error("access stage moved while asleep");

   AST_OUT_SLEEP: assert property (
      st_r.sleep_s |=> !st_r.out_valid)
      else $error("output register loaded while asleep");

   AST_HI_FIXED: assert property (
      (!stall && !strobe && st_r.active)
      |=> st_r.beat.addr[ADDR_W-1:LOW_W] == $past(st_r.addr_hi))
      else $error("upper address bits moved inside a burst");

   AST_PROC_READ: assert property (
      (!stall && strobe && enabled && rd_only) |=> st_r.beat.valid && st_r.beat.rd)
      else $error("processor strobe did not start a read");

   AST_DESEL_NO_LATCH: assert property (
      (!stall && strobe && !enabled) |=> $stable(st_r.addr_hi))
      else $error("deselected access latched an address");

endmodule

// file: rtl/pbs_pkg.sv
package pbs_pkg;

   // ==========================================================
   // array organisation (wide variant: 256K words of 36 bits)
   // ==========================================================
   localparam int ADDR_W     = 18;
   localparam int WORDS      = 262144;
   localparam int BYTES      = 4;
   localparam int BYTE_W     = 9;
   localparam int DQ_BYTE_W  = 8;
   localparam int WORD_W     = BYTES * BYTE_W;
   localparam int DQ_W       = BYTES * DQ_BYTE_W;
   // narrow variant would be 512K words of 18 bits: 19 address bits, 2 bytes
   localparam int NARROW_ADDR_W = 19;
   localparam int NARROW_BYTES  = 2;

   // ==========================================================
   // burst counter and read buffer
   // ==========================================================
   localparam int LOW_W      = 2;
   localparam int FIFO_DEPTH = 4;

   localparam logic [BYTES-1:0] MASK_ALL  = 4'hf;
   localparam logic [BYTES-1:0] MASK_NONE = 4'h0;

   // ==========================================================
   // carriers
   // ==========================================================
   typedef struct packed {
      logic                strobe_p_n;
      logic                strobe_c_n;
      logic                adv_n;
      logic                cs1_n;
      logic                cs2;
      logic                cs3_n;
      logic                gw_n;
      logic                bwe_n;
      logic [BYTES-1:0]    bw_n;
      logic                order_lin;
      logic [ADDR_W-1:0]   addr;
      logic [WORD_W-1:0]   wdata;
   } pbs_pins_t;

   typedef struct packed {
      logic                valid;
      logic                rd;
      logic [ADDR_W-1:0]   addr;
      logic [BYTES-1:0]    mask;
      logic [WORD_W-1:0]   data;
   } pbs_beat_t;

   localparam pbs_pins_t PINS_RESET = '{
      strobe_p_n: 1'b1,
      strobe_c_n: 1'b1,
      adv_n:      1'b1,
      cs1_n:      1'b1,
      gw_n:       1'b1,
      bwe_n:      1'b1,
      bw_n:       4'hf,
      default:    '0
   };

endpackage

// file: rtl/pbs_burst_ctr.sv
module pbs_burst_ctr
   import pbs_pkg::*;
(
   input  wire logic             sys_clk_i,
   input  wire logic             reset_i,
   input  wire logic             load_i,
   input  wire logic [LOW_W-1:0] start_i,
   input  wire logic             step_i,
   input  wire logic             linear_i,
   output logic      [LOW_W-1:0] low_o
);

   typedef struct packed {
      logic [LOW_W-1:0] start;
      logic [LOW_W-1:0] count;
   } pbs_ctr_state_t;

   pbs_ctr_state_t st_r;
   pbs_ctr_state_t st_nxt;

   // ==========================================================
   // counter
   // ==========================================================
   // low_o is the next value, so the first beat already sees the load
   always_comb begin
      st_nxt = st_r;
      if (load_i) begin
         st_nxt.start = start_i;
         st_nxt.count = '0;
      end else if (step_i) begin
         st_nxt.count = st_r.count + 1'b1;
      end
      if (linear_i) begin
         low_o = st_nxt.start + st_nxt.count;
      end else begin
         low_o = st_nxt.start ^ st_nxt.count;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // checks
   // ==========================================================
   AST_LOAD_START: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      load_i |-> low_o == start_i)
      else $error("burst does not open at the latched low address");

   AST_WRAP_FOUR: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      (step_i && !load_i && st_r.count == '1) |-> low_o == st_r.start)
      else $error("burst counter does not wrap after four beats");

   AST_INTERLEAVED: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      (!linear_i && step_i && !load_i && st_r.count == '0)
      |-> low_o == {st_r.start[1], ~st_r.start[0]})
      else $error("interleaved second beat wrong");

   AST_LINEAR: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      (linear_i && step_i && !load_i && st_r.count == '0)
      |-> low_o == st_r.start + 1'b1)
      else $error("linear second beat wrong");

endmodule

// file: rtl/pbs_fifo.sv
module pbs_fifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 4
) (
   input  wire logic             sys_clk_i,
   input  wire logic             reset_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0]   FULL_CNT = (AW + 1)'(DEPTH);
   localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] slot;
      logic [AW-1:0]               wr_ptr;
      logic [AW-1:0]               rd_ptr;
      logic [AW:0]                 count;
   } pbs_fifo_state_t;

   pbs_fifo_state_t st_r;
   pbs_fifo_state_t st_nxt;
   logic            push;
   logic            pop;

   assign in_ready_o  = (st_r.count != FULL_CNT);
   assign out_valid_o = (st_r.count != '0);
   assign out_data_o  = st_r.slot[st_r.rd_ptr];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   // ==========================================================
   // pointers and count
   // ==========================================================
   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.slot[st_r.wr_ptr] = in_data_i;
         st_nxt.wr_ptr = (st_r.wr_ptr == LAST_PTR) ? '0 : st_r.wr_ptr + 1'b1;
      end
      if (pop) begin
         st_nxt.rd_ptr = (st_r.rd_ptr == LAST_PTR) ? '0 : st_r.rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         st_nxt.count = st_r.count + 1'b1;
      end else if (pop && !push) begin
         st_nxt.count = st_r.count - 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   AST_FIFO_BOUND: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      (push && !pop) |=> st_r.count == $past(st_r.count) + 1'b1 && st_r.count <= FULL_CNT)
      else $error("fifo count broken on push");

endmodule

// file: tb/pbs_host.sv
module pbs_host
   import pbs_pkg::*;
(
   input  wire logic sys_clk_i,
   output pbs_pins_t pins_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // bus cycles, driven at the falling edge
   // ==========================================================
   initial pins_o = PINS_RESET;

   // released data lines show the inverse of the last word, never a stale copy
   task automatic cyc(input pbs_pins_t p, input logic wr);
      @(negedge sys_clk_i);
      if (!wr) p.wdata = ~pins_o.wdata;
      pins_o = p;
   endtask

   task automatic start(input logic [ADDR_W-1:0] a, input logic lin, input logic proc,
                        input logic gw_n, input logic bwe_n, input logic [BYTES-1:0] bw_n,
                        input logic [WORD_W-1:0] d);
      pbs_pins_t p;
      p = PINS_RESET;
      p.cs1_n = 1'b0;
      p.cs2 = 1'b1;
      p.addr = a;
      p.order_lin = lin;
      p.gw_n = gw_n;
      p.bwe_n = bwe_n;
      p.bw_n = bw_n;
      p.wdata = d;
      if (proc) p.strobe_p_n = 1'b0;
      else p.strobe_c_n = 1'b0;
      cyc(p, !gw_n || !bwe_n);
   endtask

   // burst continuation; write controls kept only for a write beat
   task automatic next(input logic adv_n, input logic [ADDR_W-1:0] a, input logic wr,
                       input logic [WORD_W-1:0] d);
      pbs_pins_t p;
      p = pins_o;
      p.strobe_p_n = 1'b1;
      p.strobe_c_n = 1'b1;
      p.adv_n = adv_n;
      p.addr = a;
      p.wdata = d;
      if (!wr) begin
         p.gw_n = 1'b1;
         p.bwe_n = 1'b1;
         p.bw_n = 4'hf;
      end
      cyc(p, wr);
   endtask

   task automatic desel(input logic strobe);
      pbs_pins_t p;
      p = PINS_RESET;
      p.order_lin = pins_o.order_lin;
      p.strobe_c_n = !strobe;
      cyc(p, 1'b0);
   endtask

   // strobe with one chip select inactive, so each select is seen refusing
   task automatic desel_by(input int which);
      pbs_pins_t p;
      p = PINS_RESET;
      p.order_lin = pins_o.order_lin;
      p.strobe_c_n = 1'b0;
      p.cs1_n = (which == 0);
      p.cs2 = (which != 1);
      p.cs3_n = (which == 2);
      cyc(p, 1'b0);
   endtask
endmodule

// file: tb/tb_top.sv
module tb_top
   import pbs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic                   sys_clk;
   logic                   reset;
   logic                   oe_n;
   logic                   sleep;
   pbs_pins_t              pins;
   logic [DQ_W-1:0]        data_o;
   logic                   data_oe;
   logic [BYTES-1:0]       par_o;
   logic                   par_oe;
   logic [WORD_W-1:0]      mem [int];
   int                     fail_count;
   int                     comparisons;
   int                     desel_pick;
   logic [BYTES-1:0]       bw_t  [5] = '{4'he, 4'hc, 4'h0, 4'hf, 4'h0};
   logic                   gw_t  [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
   logic                   bwe_t [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

   // ==========================================================
   // clock, design and far side
   // ==========================================================
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   pbs_host u_host (.sys_clk_i(sys_clk), .pins_o(pins));

   pbs_sram_top DUT (
      .sys_clk_i             (sys_clk),
      .reset_i               (reset),
      .addr_i                (pins.addr),
      .proc_addr_strobe_n_i  (pins.strobe_p_n),
      .ctrl_addr_strobe_n_i  (pins.strobe_c_n),
      .burst_advance_n_i     (pins.adv_n),
      .chip_sel_primary_n_i  (pins.cs1_n),
      .chip_sel_depth_hi_i   (pins.cs2),
      .chip_sel_depth_lo_n_i (pins.cs3_n),
      .byte_write_sel_n_i    (pins.bw_n),
      .byte_write_en_n_i     (pins.bwe_n),
      .all_bytes_write_n_i   (pins.gw_n),
      .burst_order_linear_i  (pins.order_lin),
      .output_enable_n_i     (oe_n),
      .sleep_request_i       (sleep),
      .data_i                (pins.wdata[DQ_W-1:0]),
      .data_o                (data_o),
      .data_oe_o             (data_oe),
      .parity_io_i           (pins.wdata[WORD_W-1:DQ_W]),
      .parity_io_o           (par_o),
      .parity_io_oe_o        (par_oe)
   );

   // ==========================================================
   // helpers
   // ==========================================================
   task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp,
                        input string what);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
      end
   endtask

   function automatic logic [ADDR_W-1:0] baddr(input logic [ADDR_W-1:0] a, input int n,
                                               input logic lin);
      logic [LOW_W-1:0] s;
      s = lin ? a[1:0] + n[1:0] : a[1:0] ^ n[1:0];
      return {a[ADDR_W-1:2], s};
   endfunction

   task automatic write_burst(input logic [ADDR_W-1:0] a, input logic lin,
                              input logic [WORD_W-1:0] d);
      u_host.start(a, lin, 1'b0, 1'b0, 1'b1, 4'hf, d);
      mem[a] = d;
      for (int n = 1; n < 4; n++) begin
         u_host.next(1'b0, a, 1'b1, d + WORD_W'(n));
         mem[baddr(a, n, lin)] = d + WORD_W'(n);
      end
      u_host.desel(1'b1);
      u_host.desel(1'b0);
   endtask

   task automatic write_one(input logic [ADDR_W-1:0] a, input logic gw_n, input logic bwe_n,
                            input logic [BYTES-1:0] bw_n, input logic [WORD_W-1:0] d);
      logic [WORD_W-1:0] w;
      w = mem[a];
      u_host.start(a, 1'b0, 1'b0, gw_n, bwe_n, bw_n, d);
      for (int k = 0; k < BYTES; k++) begin
         if (!gw_n || (!bwe_n && !bw_n[k])) begin
            w[8*k +: 8] = d[8*k +: 8];
            w[DQ_W+k] = d[DQ_W+k];
         end
      end
      mem[a] = w;
      u_host.desel(1'b1);
      u_host.desel(1'b0);
   endtask

   // four beats, deselect strobe in cycle 4, output pins toggled during beat 1
   task automatic read_burst(input logic [ADDR_W-1:0] a, input logic lin, input logic proc);
      u_host.start(a, lin, proc, 1'b1, 1'b1, 4'hf, '0);
      for (int i = 1; i <= 8; i++) begin
         if (i <= 3) u_host.next(1'b0, a, 1'b0, '0);
         else if (i == 4) u_host.desel_by(desel_pick % 3);
         else u_host.desel(1'b0);
         if (i == 3) check({par_oe, data_oe}, 2'b00, "not early");
         if (i >= 4 && i <= 7) begin
            check({par_o, data_o}, mem[baddr(a, i - 4, lin)], "beat");
            check({par_oe, data_oe}, 2'b11, "oe in beat");
         end
         if (i == 5) begin
            oe_n = 1'b1;
            #0.5 check(data_oe, 1'b0, "oe high");
            oe_n = 1'b0;
            sleep = 1'b1;
            #0.5 check(data_oe, 1'b0, "sleep");
            sleep = 1'b0;
            #0.5 check(data_oe, 1'b1, "oe back");
         end
         if (i == 8) check({par_oe, data_oe}, 2'b00, "deselect");
      end
      desel_pick++;
   endtask

   // ==========================================================
   // scenarios
   // ==========================================================
   task automatic t_orders;
      write_burst(18'h01232, 1'b0, 36'h9_1111_0000);
      write_burst(18'h2a5c1, 1'b1, 36'h6_2222_0000);
      read_burst(18'h01233, 1'b1, 1'b1);
      read_burst(18'h01231, 1'b0, 1'b0);
      read_burst(18'h2a5c2, 1'b0, 1'b0);
      read_burst(18'h2a5c3, 1'b1, 1'b1);
      $display("test orders done");
   endtask

   // address pins move without a strobe: the same word must repeat
   task automatic t_suspend;
      u_host.start(18'h01230, 1'b0, 1'b1, 1'b1, 1'b1, 4'hf, '0);
      for (int i = 1; i <= 7; i++) begin
         if (i <= 4) u_host.next(1'b1, 18'h01334, 1'b0, '0);
         else u_host.desel(i == 5);
         if (i >= 4) check({par_o, data_o}, mem[18'h01230], "suspend");
      end
      $display("test suspend done");
   endtask

   task automatic t_bytes;
      for (int c = 0; c < 5; c++) begin
         write_one(18'h01232, gw_t[c], bwe_t[c], bw_t[c], 36'h9_c3c3_c3c0 + WORD_W'(c));
         read_burst(18'h01232, 1'b0, 1'b0);
      end
      $display("test byte writes done");
   endtask

   // a write attempted while asleep must leave the array untouched
   task automatic t_sleep;
      sleep = 1'b1;
      repeat (4) @(negedge sys_clk);
      check(data_oe, 1'b0, "asleep");
      u_host.start(18'h01231, 1'b0, 1'b0, 1'b0, 1'b1, 4'hf, ~mem[18'h01231]);
      u_host.desel(1'b1);
      u_host.desel(1'b0);
      sleep = 1'b0;
      repeat (4) u_host.desel(1'b0);
      read_burst(18'h01231, 1'b0, 1'b0);
      $display("test sleep done");
   endtask

   task automatic test_done;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // ==========================================================
   // main sequence and watchdog
   // ==========================================================
   initial begin
      fail_count = 0;
      comparisons = 0;
      oe_n = 1'b0;
      sleep = 1'b0;
      reset = 1'b1;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      reset = 1'b0;
      t_orders;
      t_suspend;
      t_bytes;
      t_sleep;
      test_done;
   end

   // whole run needs well under 300 cycles
   initial begin
      repeat (3000) @(posedge sys_clk);
      fail_count++;
      test_done;
   end
endmodule
